//--- tmc_meas_config.sv
// Temperature correction registers and measurement configuration register
`timescale 1ns/1ps
// How it works
// - The local result gets the local correction register added as a signed quarter-degree value.
// - The second remote result gets its own signed quarter-degree correction added.
// - With the global lock set, writes to every correction register are dropped without effect.
// - All correction registers reset to zero so no correction applies until software writes one.
// - Config bits 0 to 3 choose per fan between pulse counting (clear) and two-wire resistor sensing (set).
// - Config bit 4 turns averaging off for temperature and voltage conversions.
// - Config bit 5 removes the divider from the 2.5 V input.
// - Config bit 6 replaces round-robin with repeated conversion of one selected input.
// - In single-channel mode with the test start bit set, conversions start on the external start clock.
// - The single channel comes from the three top bits of the first fan minimum-speed high byte.
// - Select codes 000, 010, 101, 110, 111 pick 2.5 V, supply, remote 1, local and remote 2.
// - Config bit 7 powers down: fan drives go inactive and duty readback shows zero.
// - The first remote result gets its own signed quarter-degree correction added.
module tmc_meas_config #(
	parameter int TEMP_W = tmc_pkg::TMC_TEMP_W,
	parameter int CORR_W = tmc_pkg::TMC_CORR_W,
	parameter int FAN_COUNT = tmc_pkg::TMC_FAN_COUNT,
	parameter int PWM_COUNT = tmc_pkg::TMC_PWM_COUNT
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic ce,
	// Register port from the serial management engine
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Neighbouring register bits
	input wire logic config_lock,
	input wire logic ext_start_enable,
	input wire logic [7:0] fan1_min_high_byte,
	// External conversion start pin, asynchronous
	input wire logic ext_start_pin,
	// Raw results from the converter
	input wire logic [TEMP_W-1:0] raw_remote1_temp,
	input wire logic [TEMP_W-1:0] raw_local_temp,
	input wire logic [TEMP_W-1:0] raw_remote2_temp,
	input wire logic [tmc_pkg::TMC_TEMP_CHANNELS-1:0] raw_temp_valid,
	output logic [TEMP_W-1:0] remote1_temp,
	output logic [TEMP_W-1:0] local_temp,
	output logic [TEMP_W-1:0] remote2_temp,
	output logic [tmc_pkg::TMC_TEMP_CHANNELS-1:0] temp_valid,
	// Configuration outputs to the sequencer and fan logic
	output logic [FAN_COUNT-1:0] fan_two_wire_sense,
	output logic averaging_disable,
	output logic input_divider_bypass,
	output logic single_channel_convert,
	output tmc_pkg::tmc_chan_t single_channel_sel,
	output logic ext_clock_start_mode,
	output logic ext_convert_start,
	output logic power_down,
	// Fan drive and duty readback
	input wire logic [PWM_COUNT-1:0] fan_drive_in,
	input wire logic [PWM_COUNT-1:0] fan_inactive_level,
	input wire logic [PWM_COUNT*8-1:0] duty_current_in,
	output logic [PWM_COUNT-1:0] fan_drive_out,
	output logic [PWM_COUNT*8-1:0] duty_current_read
);
	import tmc_pkg::*;

	// ==========================================
	// Decode of the single-channel select field
	function automatic tmc_chan_t decode_channel(input logic [2:0] code);
		tmc_chan_t ch;
		ch = TMC_CHAN_NONE;
		if (code == TMC_SEL_2V5) begin
			ch = TMC_CHAN_2V5;
		end else if (code == TMC_SEL_SUPPLY) begin
			ch = TMC_CHAN_SUPPLY;
		end else if (code == TMC_SEL_REMOTE1) begin
			ch = TMC_CHAN_REMOTE1;
		end else if (code == TMC_SEL_LOCAL) begin
			ch = TMC_CHAN_LOCAL;
		end else if (code == TMC_SEL_REMOTE2) begin
			ch = TMC_CHAN_REMOTE2;
		end
		return ch;
	endfunction

	logic [CORR_W-1:0] corr_reg [TMC_TEMP_CHANNELS];
	logic [7:0] config_reg;
	logic [TEMP_W-1:0] raw_temp [TMC_TEMP_CHANNELS];
	logic [TEMP_W-1:0] corr_temp [TMC_TEMP_CHANNELS];
	logic [TMC_TEMP_CHANNELS-1:0] corr_hit;
	logic config_hit;
	logic write_ok;
	logic [7:0] rdata_next;
	logic start_sync1_reg;
	logic start_sync2_reg;
	logic start_prev_reg;
	logic start_edge;
	logic start_pulse_reg;
	logic [PWM_COUNT-1:0] drive_reg;
	logic [PWM_COUNT*8-1:0] duty_reg;

	// ==========================================
	// Address decode; locked registers ignore writes silently
	assign write_ok = reg_wr && !config_lock;
	assign corr_hit[TMC_CH_REMOTE1] = (reg_addr == TMC_ADDR_REMOTE1_CORR);
	assign corr_hit[TMC_CH_LOCAL] = (reg_addr == TMC_ADDR_LOCAL_CORR);
	assign corr_hit[TMC_CH_REMOTE2] = (reg_addr == TMC_ADDR_REMOTE2_CORR);
	assign config_hit = (reg_addr == TMC_ADDR_MEAS_CONFIG);

	assign raw_temp[TMC_CH_REMOTE1] = raw_remote1_temp;
	assign raw_temp[TMC_CH_LOCAL] = raw_local_temp;
	assign raw_temp[TMC_CH_REMOTE2] = raw_remote2_temp;

	// ==========================================
	// Correction registers and adders, one per temperature channel
	for (genvar i = 0; i < TMC_TEMP_CHANNELS; i++) begin : g_chan
		always_ff @(posedge ref_clk or negedge nrst) begin
			if (!nrst) begin
				corr_reg[i] <= TMC_CORR_RESET;
			end else if (ce && write_ok && corr_hit[i]) begin
				corr_reg[i] <= reg_wdata;
			end
		end

		// Corrected value is what gets stored, so limit logic never sees raw data
		tmc_temp_correct #(
			.TEMP_W(TEMP_W),
			.CORR_W(CORR_W)
		) u_correct (
			.ref_clk(ref_clk),
			.nrst(nrst),
			.ce(ce),
			.raw_temp(raw_temp[i]),
			.raw_valid(raw_temp_valid[i]),
			.correction(corr_reg[i]),
			.corrected_temp(corr_temp[i]),
			.corrected_valid(temp_valid[i])
		);
	end

	assign remote1_temp = corr_temp[TMC_CH_REMOTE1];
	assign local_temp = corr_temp[TMC_CH_LOCAL];
	assign remote2_temp = corr_temp[TMC_CH_REMOTE2];

	// ==========================================
	// Measurement configuration register
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			config_reg <= TMC_CONFIG_RESET;
		end else if (ce && write_ok && config_hit) begin
			config_reg <= reg_wdata;
		end
	end

	// Field breakout to the sequencer and fan speed logic
	assign fan_two_wire_sense = config_reg[TMC_FAN_SENSE_LSB +: FAN_COUNT];
	assign averaging_disable = config_reg[TMC_BIT_AVG_DISABLE];
	assign input_divider_bypass = config_reg[TMC_BIT_DIV_BYPASS];
	assign single_channel_convert = config_reg[TMC_BIT_SINGLE_SINGLE_CHANNEL_CONVERT];
	assign power_down = config_reg[TMC_BIT_POWER_DOWN];
	// Undefined codes give no channel; the sequencer then holds off
	assign single_channel_sel = single_channel_convert ?
		decode_channel(fan1_min_high_byte[7:5]) : TMC_CHAN_NONE;
	assign ext_clock_start_mode = single_channel_convert && ext_start_enable;

	// ==========================================
	// External start pin: two-stage sync, then rising-edge detect
	assign start_edge = start_sync2_reg && !start_prev_reg;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			start_sync1_reg <= 1'b0;
			start_sync2_reg <= 1'b0;
			start_prev_reg <= 1'b0;
			start_pulse_reg <= 1'b0;
		end else if (ce) begin
			start_sync1_reg <= ext_start_pin;
			start_sync2_reg <= start_sync1_reg;
			start_prev_reg <= start_sync2_reg;
			start_pulse_reg <= start_edge && ext_clock_start_mode;
		end
	end

	assign ext_convert_start = start_pulse_reg;

	// ==========================================
	// Power-down gating of fan drives and duty readback
	for (genvar p = 0; p < PWM_COUNT; p++) begin : g_pwm
		always_ff @(posedge ref_clk or negedge nrst) begin
			if (!nrst) begin
				drive_reg[p] <= 1'b0;
				duty_reg[p*8 +: 8] <= TMC_DUTY_OFF;
			end else if (ce) begin
				drive_reg[p] <= power_down ? fan_inactive_level[p] : fan_drive_in[p];
				duty_reg[p*8 +: 8] <= power_down ? TMC_DUTY_OFF : duty_current_in[p*8 +: 8];
			end
		end
	end

	assign fan_drive_out = drive_reg;
	assign duty_current_read = duty_reg;

	// ==========================================
	// Read mux, registered; unmapped addresses read zero
	assign rdata_next = corr_hit[TMC_CH_REMOTE1] ? corr_reg[TMC_CH_REMOTE1] :
		corr_hit[TMC_CH_LOCAL] ? corr_reg[TMC_CH_LOCAL] :
		corr_hit[TMC_CH_REMOTE2] ? corr_reg[TMC_CH_REMOTE2] :
		config_hit ? config_reg : TMC_READ_UNMAPPED;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= TMC_READ_UNMAPPED;
		end else if (ce && reg_rd) begin
			reg_rdata <= rdata_next;
		end
	end
endmodule // tmc_meas_config

//--- tmc_pkg.sv
// Shared constants for the temperature correction and measurement configuration block
package tmc_pkg;
	// ==========================================
	// Register map
	localparam logic [7:0] TMC_ADDR_REMOTE1_CORR = 8'h70;
	localparam logic [7:0] TMC_ADDR_LOCAL_CORR = 8'h71;
	localparam logic [7:0] TMC_ADDR_REMOTE2_CORR = 8'h72;
	localparam logic [7:0] TMC_ADDR_MEAS_CONFIG = 8'h73;
	localparam logic [7:0] TMC_CORR_RESET = 8'h00;
	localparam logic [7:0] TMC_CONFIG_RESET = 8'h00;
	localparam logic [7:0] TMC_READ_UNMAPPED = 8'h00;
	localparam logic [7:0] TMC_DUTY_OFF = 8'h00;

	// ==========================================
	// Measurement configuration fields
	localparam int TMC_FAN_SENSE_LSB = 0;
	localparam int TMC_FAN_COUNT = 4;
	localparam int TMC_BIT_AVG_DISABLE = 4;
	localparam int TMC_BIT_DIV_BYPASS = 5;
	localparam int TMC_BIT_SINGLE_SINGLE_CHANNEL_CONVERT = 6;
	localparam int TMC_BIT_POWER_DOWN = 7;

	// ==========================================
	// Temperature format: two fraction bits, one step is a quarter degree
	localparam int TMC_TEMP_W = 10;
	localparam int TMC_CORR_W = 8;
	localparam int TMC_TEMP_CHANNELS = 3;
	localparam int TMC_CH_REMOTE1 = 0;
	localparam int TMC_CH_LOCAL = 1;
	localparam int TMC_CH_REMOTE2 = 2;
	localparam int TMC_PWM_COUNT = 3;

	// ==========================================
	// Single-channel select codes
	localparam logic [2:0] TMC_SEL_2V5 = 3'h0;
	localparam logic [2:0] TMC_SEL_SUPPLY = 3'h2;
	localparam logic [2:0] TMC_SEL_REMOTE1 = 3'h5;
	localparam logic [2:0] TMC_SEL_LOCAL = 3'h6;
	localparam logic [2:0] TMC_SEL_REMOTE2 = 3'h7;

	typedef enum logic [2:0] {
		TMC_CHAN_2V5,
		TMC_CHAN_SUPPLY,
		TMC_CHAN_REMOTE1,
		TMC_CHAN_LOCAL,
		TMC_CHAN_REMOTE2,
		TMC_CHAN_NONE
	} tmc_chan_t;
endpackage

//--- tmc_temp_correct.sv
// Adds a signed quarter-degree correction to one raw temperature result
`timescale 1ns/1ps
module tmc_temp_correct #(
	parameter int TEMP_W = tmc_pkg::TMC_TEMP_W,
	parameter int CORR_W = tmc_pkg::TMC_CORR_W
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic [TEMP_W-1:0] raw_temp,
	input wire logic raw_valid,
	input wire logic [CORR_W-1:0] correction,
	output logic [TEMP_W-1:0] corrected_temp,
	output logic corrected_valid
);
	import tmc_pkg::*;

	localparam int SUM_W = TEMP_W + 1;

	logic signed [SUM_W-1:0] raw_ext;
	logic signed [SUM_W-1:0] corr_ext;
	logic signed [SUM_W-1:0] sum;
	logic overflow_pos;
	logic overflow_neg;
	logic [TEMP_W-1:0] sat_value;
	logic [TEMP_W-1:0] max_value;
	logic [TEMP_W-1:0] min_value;

	// ==========================================
	// Sign-extended sum, one guard bit catches overflow
	assign raw_ext = SUM_W'($signed(raw_temp));
	assign corr_ext = SUM_W'($signed(correction));
	assign sum = raw_ext + corr_ext;
	assign max_value = {1'b0, {(TEMP_W-1){1'b1}}};
	assign min_value = {1'b1, {(TEMP_W-1){1'b0}}};
	// Clamp instead of wrapping: a wrapped hot reading would look cold to limit logic
	assign overflow_pos = (sum[SUM_W-1] == 1'b0) && (sum[TEMP_W-1] == 1'b1);
	assign overflow_neg = (sum[SUM_W-1] == 1'b1) && (sum[TEMP_W-1] == 1'b0);
	assign sat_value = overflow_pos ? max_value : (overflow_neg ? min_value : sum[TEMP_W-1:0]);

	// ==========================================
	// Result register, updated only when a new raw result arrives
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			corrected_temp <= '0;
			corrected_valid <= 1'b0;
		end else if (ce) begin
			corrected_valid <= raw_valid;
			if (raw_valid) begin
				corrected_temp <= sat_value;
			end
		end
	end
endmodule // tmc_temp_correct

//--- tmc_meas_config_asserts.sv
// Checker for the correction and measurement configuration block
`timescale 1ns/1ps
module tmc_meas_config_asserts
import tmc_pkg::*;
#(
	parameter int FAN_COUNT = 4,
	parameter int PWM_COUNT = 3
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic config_lock,
	input wire logic ext_start_enable,
	input wire logic [7:0] fan1_min_high_byte,
	input wire logic [2:0] raw_temp_valid,
	input wire logic [2:0] temp_valid,
	input wire logic [FAN_COUNT-1:0] fan_two_wire_sense,
	input wire logic averaging_disable,
	input wire logic input_divider_bypass,
	input wire logic single_channel_convert,
	input wire tmc_chan_t single_channel_sel,
	input wire logic ext_clock_start_mode,
	input wire logic ext_convert_start,
	input wire logic power_down,
	input wire logic [PWM_COUNT-1:0] fan_inactive_level,
	input wire logic [PWM_COUNT-1:0] fan_drive_out,
	input wire logic [PWM_COUNT*8-1:0] duty_current_read
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// ==========================================
	// Config fields gathered back into register order
	wire logic [FAN_COUNT+3:0] cfg_bits = {power_down, single_channel_convert, input_divider_bypass,
		averaging_disable, fan_two_wire_sense};
	property p_valid_lat;
		ce && (|raw_temp_valid) |=> temp_valid == $past(raw_temp_valid);
	endproperty
	a_valid_lat: assert property (p_valid_lat) else $error("result valid lost");
	property p_cfg_write;
		ce && reg_wr && !config_lock && reg_addr == TMC_ADDR_MEAS_CONFIG |=> cfg_bits == $past(reg_wdata);
	endproperty
	a_cfg_write: assert property (p_cfg_write) else $error("config write not applied");
	property p_cfg_lock;
		ce && reg_wr && config_lock && reg_addr == TMC_ADDR_MEAS_CONFIG |=> $stable(cfg_bits);
	endproperty
	a_cfg_lock: assert property (p_cfg_lock) else $error("locked config changed");
	property p_sel_off;
		!single_channel_convert |-> single_channel_sel == TMC_CHAN_NONE;
	endproperty
	a_sel_off: assert property (p_sel_off) else $error("channel chosen outside single mode");
	property p_sel_local;
		single_channel_convert && fan1_min_high_byte[7:5] == TMC_SEL_LOCAL |-> single_channel_sel == TMC_CHAN_LOCAL;
	endproperty
	a_sel_local: assert property (p_sel_local) else $error("local code misdecoded");
	property p_ext_mode;
		ext_clock_start_mode == (single_channel_convert && ext_start_enable);
	endproperty
	a_ext_mode: assert property (p_ext_mode) else $error("external start mode wrong");
	property p_ext_gate;
		!ext_clock_start_mode [*3] |=> !ext_convert_start;
	endproperty
	a_ext_gate: assert property (p_ext_gate) else $error("start pulse with mode off");
	property p_ext_pulse;
		ext_convert_start |=> !ext_convert_start;
	endproperty
	a_ext_pulse: assert property (p_ext_pulse) else $error("start pulse too long");
	property p_pd_fan;
		ce && power_down |=> fan_drive_out == $past(fan_inactive_level);
	endproperty
	a_pd_fan: assert property (p_pd_fan) else $error("fan drive active in power down");
	property p_pd_duty;
		ce && power_down |=> duty_current_read == '0;
	endproperty
	a_pd_duty: assert property (p_pd_duty) else $error("duty readback not zero");
	// Main scenarios reached
	c_pd: cover property (ce && power_down);
	c_ext: cover property (ext_convert_start);
	c_lock: cover property (reg_wr && config_lock);
endmodule // tmc_meas_config_asserts

bind tmc_meas_config tmc_meas_config_asserts #(.FAN_COUNT(FAN_COUNT), .PWM_COUNT(PWM_COUNT))
	tmc_meas_config_asserts_inst (.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .reg_wdata(reg_wdata), .config_lock(config_lock), .ext_start_enable(ext_start_enable),
	.fan1_min_high_byte(fan1_min_high_byte), .raw_temp_valid(raw_temp_valid), .temp_valid(temp_valid),
	.fan_two_wire_sense(fan_two_wire_sense), .averaging_disable(averaging_disable),
	.input_divider_bypass(input_divider_bypass), .single_channel_convert(single_channel_convert),
	.single_channel_sel(single_channel_sel), .ext_clock_start_mode(ext_clock_start_mode),
	.ext_convert_start(ext_convert_start), .power_down(power_down), .fan_inactive_level(fan_inactive_level),
	.fan_drive_out(fan_drive_out), .duty_current_read(duty_current_read));

//--- tmc_meas_config_tb.sv
// Self-checking bench for the correction and measurement configuration block
`timescale 1ns/1ps
module tmc_meas_config_tb;
	import tmc_pkg::*;
	logic ref_clk = 1'b0, nrst = 1'b0, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, config_lock = 1'b0;
	logic ext_start_enable = 1'b0, ext_start_pin = 1'b0;
	logic [7:0] reg_addr = '0, reg_wdata = '0, fan1_min_high_byte = '0, reg_rdata, rd_val;
	logic [9:0] raw_remote1_temp = '0, raw_local_temp = '0, raw_remote2_temp = '0;
	logic [9:0] remote1_temp, local_temp, remote2_temp;
	logic [2:0] raw_temp_valid = '0, temp_valid, fan_drive_in = '0, fan_inactive_level = '0, fan_drive_out;
	logic [23:0] duty_current_in = '0, duty_current_read;
	logic [3:0] fan_two_wire_sense;
	logic averaging_disable, input_divider_bypass, single_channel_convert, ext_clock_start_mode, ext_convert_start;
	logic power_down;
	tmc_chan_t single_channel_sel;
	int fails = 0, samples_checked = 0;
	tmc_meas_config tmc_meas_config_inst (.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .config_lock(config_lock),
		.ext_start_enable(ext_start_enable), .fan1_min_high_byte(fan1_min_high_byte), .ext_start_pin(ext_start_pin),
		.raw_remote1_temp(raw_remote1_temp), .raw_local_temp(raw_local_temp), .raw_remote2_temp(raw_remote2_temp),
		.raw_temp_valid(raw_temp_valid), .remote1_temp(remote1_temp), .local_temp(local_temp),
		.remote2_temp(remote2_temp), .temp_valid(temp_valid), .fan_two_wire_sense(fan_two_wire_sense),
		.averaging_disable(averaging_disable), .input_divider_bypass(input_divider_bypass),
		.single_channel_convert(single_channel_convert), .single_channel_sel(single_channel_sel),
		.ext_clock_start_mode(ext_clock_start_mode), .ext_convert_start(ext_convert_start), .power_down(power_down),
		.fan_drive_in(fan_drive_in), .fan_inactive_level(fan_inactive_level), .duty_current_in(duty_current_in),
		.fan_drive_out(fan_drive_out), .duty_current_read(duty_current_read));
	// ==========================================
	// Clock, 8 ns period
	initial forever #4 ref_clk = ~ref_clk;
	// ==========================================
	// Shared helpers; reads sample after the edge lands
	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(logic [7:0] a);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		rd_val = reg_rdata;
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// ==========================================
	// Scenarios
	task automatic t_reset();
		for (int i = 0; i < 4; i++) begin
			rd(8'h70 + 8'(i));
			check("reset value", rd_val, 8'h00);
		end
	endtask
	task automatic t_corr();
		wr(TMC_ADDR_REMOTE1_CORR, 8'h04);
		wr(TMC_ADDR_LOCAL_CORR, 8'hfc);
		wr(TMC_ADDR_REMOTE2_CORR, 8'h80);
		@(posedge ref_clk);
		raw_remote1_temp <= 10'h064;
		raw_local_temp <= 10'h064;
		raw_remote2_temp <= 10'h064;
		raw_temp_valid <= 3'h7;
		@(posedge ref_clk);
		raw_temp_valid <= 3'h0;
		#1;
		check("remote1", remote1_temp, 10'h068);
		check("local", local_temp, 10'h060);
		check("remote2", remote2_temp, 10'h3e4);
		check("valid", temp_valid, 3'h7);
		// A hot reading pushed past full scale must clamp, not wrap to cold
		@(posedge ref_clk);
		raw_remote1_temp <= 10'h1fe;
		raw_temp_valid <= 3'h1;
		@(posedge ref_clk);
		raw_temp_valid <= 3'h0;
		#1;
		check("remote1 clamp", remote1_temp, 10'h1ff);
	endtask
	task automatic t_cfg();
		for (int i = 0; i < 8; i++) begin
			wr(TMC_ADDR_MEAS_CONFIG, 8'h01 << i);
			check("config", {power_down, single_channel_convert, input_divider_bypass, averaging_disable,
				fan_two_wire_sense}, 8'h01 << i);
		end
	endtask
	task automatic t_sel();
		tmc_chan_t exp_sel[8] = '{TMC_CHAN_2V5, TMC_CHAN_NONE, TMC_CHAN_SUPPLY, TMC_CHAN_NONE, TMC_CHAN_NONE,
			TMC_CHAN_REMOTE1, TMC_CHAN_LOCAL, TMC_CHAN_REMOTE2};
		wr(TMC_ADDR_MEAS_CONFIG, 8'h40);
		for (int c = 0; c < 8; c++) begin
			@(posedge ref_clk);
			fan1_min_high_byte <= {3'(c), 5'h1f};
			#1;
			check("select", single_channel_sel, exp_sel[c]);
		end
		wr(TMC_ADDR_MEAS_CONFIG, 8'h00);
		check("select off", single_channel_sel, TMC_CHAN_NONE);
	endtask
	task automatic t_ext(logic en, logic [1:0] exp_n);
		logic [1:0] seen;
		seen = 2'h0;
		wr(TMC_ADDR_MEAS_CONFIG, 8'h40);
		@(posedge ref_clk);
		ext_start_enable <= en;
		ext_start_pin <= 1'b1;
		for (int k = 0; k < 8; k++) begin
			@(posedge ref_clk);
			if (k == 2) begin
				ext_start_pin <= 1'b0;
			end
			#1;
			seen += 2'(ext_convert_start);
		end
		check("ext mode", ext_clock_start_mode, en);
		check("ext pulses", seen, exp_n);
	endtask
	task automatic t_pd();
		@(posedge ref_clk);
		fan_drive_in <= 3'h5;
		fan_inactive_level <= 3'h2;
		duty_current_in <= 24'h123456;
		wr(TMC_ADDR_MEAS_CONFIG, 8'h80);
		@(posedge ref_clk);
		#1;
		check("fan drive", fan_drive_out, 3'h2);
		check("duty", duty_current_read, 24'h000000);
		wr(TMC_ADDR_MEAS_CONFIG, 8'h00);
		@(posedge ref_clk);
		#1;
		check("fan drive", fan_drive_out, 3'h5);
		check("duty", duty_current_read, 24'h123456);
	endtask
	task automatic t_ce();
		// Enable low: write and read both ignored, read data holds the old value
		@(posedge ref_clk);
		ce <= 1'b0;
		wr(TMC_ADDR_LOCAL_CORR, 8'h11);
		rd(TMC_ADDR_LOCAL_CORR);
		check("frozen read", rd_val, 8'h00);
		@(posedge ref_clk);
		ce <= 1'b1;
		rd(TMC_ADDR_LOCAL_CORR);
		check("frozen write", rd_val, 8'hfc);
	endtask
	task automatic t_lock();
		@(posedge ref_clk);
		config_lock <= 1'b1;
		wr(TMC_ADDR_LOCAL_CORR, 8'h55);
		wr(TMC_ADDR_MEAS_CONFIG, 8'hff);
		rd(TMC_ADDR_LOCAL_CORR);
		check("locked corr", rd_val, 8'hfc);
		check("locked config", power_down, 1'b0);
		rd(8'h10);
		check("unmapped", rd_val, 8'h00);
	endtask
	// Main sequence, reset held five cycles
	initial begin
		repeat (5) @(posedge ref_clk);
		nrst <= 1'b1;
		t_reset();
		t_corr();
		t_cfg();
		t_sel();
		t_ext(1'b1, 2'h1);
		t_ext(1'b0, 2'h0);
		t_pd();
		t_ce();
		t_lock();
		wrap_up();
	end
endmodule // tmc_meas_config_tb
